// ===== design/monitor_smbus_register_port.sv
// serial-bus slave register port of the system hardware monitor
// Operation
// - reset pin low restores register defaults
// - programmed reset pin pulse lasts 45 ms
// - slave address 01011 plus two strap bits
// - strap: ground 10, open 00, supply 01
// - strap sampled once after power-up only
// - START, then address MSB first, direction
// - acknowledge on match, else stay idle
// - direction 0 write, 1 read
// - nine clocks per byte, data on low
// - direction fixed for whole transfer
// - writes one or two bytes, one read byte
// - first byte pointer, second to register
// - pointer-only write changes no data register
// - read returns register at current pointer
// - status registers mirrored at 4Ch, 4Dh
// - mode bits 0,1: tach or analog
// - mode bit 2: voltages or second diode
// - mode bit 3: supply range 3.3/5.0 V
// - mode bit 7 irq mode, bits 4-6 enables
// - config2 bits 6,7 enable last two irqs
// - intrusion clear write clears intrusion latch
// - channel mode resets to zero
`default_nettype none
module monitor_smbus_register_port
    import hwmon_pkg::*;
#(
    parameter int unsigned RST_PULSE_CYC = RST_PULSE_CYC_DFLT
) (
    input  wire logic        clk,                // system clock
    input  wire logic        rst_n,              // power-up reset
    input  wire logic        scl_in,             // bus clock from master
    input  wire logic        sda_i,              // bus data line level
    output logic             sda_o,              // bus data drive value
    output logic             sda_oe,             // bus data pull low
    input  wire logic        rst_pin_i,          // reset pin level
    output logic             rst_pin_o,          // reset pin drive value
    output logic             rst_pin_oe,         // reset pin pull low
    input  wire addr_sel_t   addr_sel,           // three-state strap sense
    input  wire logic        chassis_in,         // intrusion input
    input  wire logic [4:0]  core_voltage_code,  // voltage code pins
    input  wire logic [7:0]  limit_events,       // limit compare events
    output chan_roles_t      chan_roles,         // pin role selection
    output logic [7:0]       analog_output_code  // dac code
);

    // ****************************************
    // start and stop detection
    // ****************************************
    logic        start_r;
    logic        stop_r;
    logic        link_rst_r;
    wire         link_clr = start_r | stop_r | link_rst_r;

    // high from sda falling with scl high until scl falls
    always_ff @(negedge sda_i or negedge scl_in) begin
        if (!scl_in) begin
            start_r <= 1'b0;
        end else begin
            start_r <= 1'b1;
        end
    end

    // high from sda rising with scl high until scl falls
    always_ff @(posedge sda_i or negedge scl_in) begin
        if (!scl_in) begin
            stop_r <= 1'b0;
        end else begin
            stop_r <= 1'b1;
        end
    end

    // ****************************************
    // link domain byte engine
    // ****************************************
    link_state_t state_r;
    link_state_t state_nxt;
    logic [3:0]  bit_r;
    logic [3:0]  bit_nxt;
    logic [7:0]  shift_r;
    logic [7:0]  tx_r;
    logic [7:0]  tx_nxt;
    logic        ack_due_r;
    logic        ack_nxt;
    logic        ev_fire_link;
    wr_event_t   ev_r;
    wr_event_t   ev_nxt;
    logic        ev_tgl_r;
    logic [7:0]  link_ptr_r;
    logic        sda_oe_r;
    logic [1:0]  dev_addr_lo_r;
    logic [7:0]  rd_byte_r;

    wire [7:0]   byte_in  = {shift_r[6:0], sda_i};
    wire         byte_end = (bit_r == BIT_LAST);
    wire         in_ack   = (bit_r == BIT_ACK);
    wire         addr_hit = (byte_in[7:1] == {SLAVE_ADDR_PREFIX, dev_addr_lo_r});
    wire         dir_read = byte_in[0];
    wire [2:0]   tx_idx   = 3'(BIT_LAST - bit_r);

    always_comb begin
        state_nxt    = state_r;
        bit_nxt      = bit_r;
        tx_nxt       = tx_r;
        ack_nxt      = ack_due_r;
        ev_fire_link = 1'b0;
        ev_nxt       = ev_r;
        if (state_r == LK_IDLE) begin
            bit_nxt = bit_r;
        end else if (in_ack) begin
            bit_nxt = 4'h0;
            ack_nxt = 1'b0;
        end else begin
            bit_nxt = 4'(bit_r + 4'h1);
            if (byte_end) begin
                case (state_r)
                    LK_ADDR: begin
                        if (!addr_hit) begin
                            state_nxt = LK_IDLE;
                        end else if (dir_read) begin
                            state_nxt = LK_RD;
                            tx_nxt    = rd_byte_r;
                            ack_nxt   = 1'b1;
                        end else begin
                            state_nxt = LK_WR_PTR;
                            ack_nxt   = 1'b1;
                        end
                    end
                    LK_WR_PTR: begin
                        state_nxt    = LK_WR_DATA;
                        ack_nxt      = 1'b1;
                        ev_fire_link = 1'b1;
                        ev_nxt       = '{is_data: 1'b0, ptr: byte_in, data: 8'h00};
                    end
                    LK_WR_DATA: begin
                        state_nxt    = LK_WR_IGNORE;
                        ack_nxt      = 1'b1;
                        ev_fire_link = 1'b1;
                        ev_nxt       = '{is_data: 1'b1, ptr: link_ptr_r, data: byte_in};
                    end
                    LK_WR_IGNORE: begin
                        ack_nxt = 1'b0;
                    end
                    LK_RD: begin
                        state_nxt = LK_IDLE;
                        ack_nxt   = 1'b0;
                    end
                    default: begin
                        state_nxt = LK_IDLE;
                    end
                endcase
            end
        end
    end

    // per-transfer state, cleared by start, stop or reset
    always_ff @(posedge scl_in or posedge link_clr) begin
        if (link_clr) begin
            state_r   <= LK_ADDR;
            bit_r     <= 4'h0;
            shift_r   <= 8'h00;
            tx_r      <= 8'h00;
            ack_due_r <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            bit_r     <= bit_nxt;
            shift_r   <= byte_in;
            tx_r      <= tx_nxt;
            ack_due_r <= ack_nxt;
        end
    end

    // pointer and write event survive between transfers
    always_ff @(posedge scl_in or posedge link_rst_r) begin
        if (link_rst_r) begin
            ev_r       <= '0;
            ev_tgl_r   <= 1'b0;
            link_ptr_r <= 8'h00;
        end else begin
            ev_r     <= ev_nxt;
            ev_tgl_r <= ev_tgl_r ^ ev_fire_link;
            if (ev_fire_link && !ev_nxt.is_data) begin
                link_ptr_r <= ev_nxt.ptr;
            end
        end
    end

    // data line changes only while scl is low
    wire oe_nxt = in_ack ? ack_due_r : ((state_r == LK_RD) & ~tx_r[tx_idx]);

    always_ff @(negedge scl_in or posedge link_clr) begin
        if (link_clr) begin
            sda_oe_r <= 1'b0;
        end else begin
            sda_oe_r <= oe_nxt;
        end
    end

    // ****************************************
    // input synchronisers
    // ****************************************
    localparam int SYNC_W = 10;
    wire [SYNC_W-1:0] sync_in = {ev_tgl_r, rst_pin_i, chassis_in, core_voltage_code, addr_sel};
    logic [SYNC_W-1:0] sync1_r;
    logic [SYNC_W-1:0] sync2_r;

    always_ff @(posedge clk) begin
        sync1_r <= sync_in;
        sync2_r <= sync1_r;
    end

    wire         ev_tgl_s   = sync2_r[9];
    wire         rst_pin_s  = sync2_r[8];
    wire         chassis_s  = sync2_r[7];
    wire [4:0]   code_s     = sync2_r[6:2];
    addr_sel_t   addr_sel_s;
    assign addr_sel_s = sync2_r[1:0];

    // ****************************************
    // power-up strap capture
    // ****************************************
    logic [1:0]  strap_cnt_r;
    logic        strap_done_r;
    wire  [1:0]  strap_code = addr_sel_s.tied_low  ? ADDR_LO_GND :
                              addr_sel_s.tied_high ? ADDR_LO_VCC : ADDR_LO_OPEN;
    wire         strap_take = (strap_cnt_r == STRAP_WAIT) & ~strap_done_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            link_rst_r    <= 1'b1;
            strap_cnt_r   <= 2'h0;
            strap_done_r  <= 1'b0;
            dev_addr_lo_r <= ADDR_LO_OPEN;
        end else begin
            link_rst_r <= 1'b0;
            if (!strap_done_r) begin
                strap_cnt_r <= 2'(strap_cnt_r + 2'h1);
            end
            if (strap_take) begin
                strap_done_r  <= 1'b1;
                dev_addr_lo_r <= strap_code;
            end
        end
    end

    // ****************************************
    // write event decode
    // ****************************************
    logic        ev_seen_r;
    wire         ev_fire  = ev_tgl_s ^ ev_seen_r;
    wire         wr_hit   = ev_fire & ev_r.is_data;
    wire [7:0]   wr_data  = ev_r.data;
    wire         wr_cfg1  = wr_hit & (ev_r.ptr == REG_CONFIG1);
    wire         wr_cfg2  = wr_hit & (ev_r.ptr == REG_CONFIG2);
    wire         wr_chm   = wr_hit & (ev_r.ptr == REG_CHMODE);
    wire         wr_analog_output_pin  = wr_hit & (ev_r.ptr == REG_ANALOG_OUT);
    wire         wr_vid   = wr_hit & (ev_r.ptr == REG_VID_FANDIV);
    wire         wr_st1   = wr_hit & (ev_r.ptr == REG_STATUS1);
    wire         wr_st2   = wr_hit & (ev_r.ptr == REG_STATUS2);
    wire         wr_icl   = wr_hit & (ev_r.ptr == REG_INTRUSION_CLR);
    wire         pin_rst  = ~rst_pin_s;
    wire         reg_clr  = ~rst_n | pin_rst;

    // ****************************************
    // register file
    // ****************************************
    logic [7:0]  ptr_r;
    logic [7:0]  config1_r;
    logic [7:0]  config2_r;
    logic [7:0]  chmode_r;
    logic [7:0]  analog_output_pin_r;
    logic [3:0]  fandiv_r;
    logic [7:0]  stat1_r;
    logic [7:0]  stat2_r;

    wire  [4:0]  irq_en   = {config2_r[7:6], chmode_r[6:4]};
    wire  [4:0]  irq_ev   = {5{chmode_r[CH_IRQ_MODE]}} & irq_en & ~code_s;
    wire  [7:0]  st2_set  = {2'h0, chassis_s, irq_ev};
    wire  [7:0]  st2_clr  = (wr_st2 ? wr_data : 8'h00) | (wr_icl ? 8'(1 << ST2_CHASSIS) : 8'h00);
    wire  [7:0]  st1_clr  = wr_st1 ? wr_data : 8'h00;
    wire  [7:0]  stat1_nxt = (stat1_r & ~st1_clr) | limit_events;
    wire  [7:0]  stat2_nxt = (stat2_r & ~st2_clr) | st2_set;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ev_seen_r <= 1'b0;
            ptr_r     <= 8'h00;
        end else begin
            ev_seen_r <= ev_tgl_s;
            if (ev_fire) begin
                ptr_r <= ev_r.ptr;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reg_clr) begin
            config1_r <= CONFIG1_RST;
            config2_r <= CONFIG2_RST;
            chmode_r  <= CHMODE_RST;
            analog_output_pin_r    <= ANALOG_OUT_RST;
            fandiv_r  <= FANDIV_RST;
            stat1_r   <= STATUS_RST;
            stat2_r   <= STATUS_RST;
        end else begin
            stat1_r <= stat1_nxt;
            stat2_r <= stat2_nxt;
            if (wr_cfg1) begin
                config1_r <= wr_data & ~8'(1 << CFG1_PULSE_BIT);
            end
            if (wr_cfg2) begin
                config2_r <= wr_data;
            end
            if (wr_chm) begin
                chmode_r <= wr_data;
            end
            if (wr_analog_output_pin) begin
                analog_output_pin_r <= wr_data;
            end
            if (wr_vid) begin
                fandiv_r <= wr_data[7:4];
            end
        end
    end

    // ****************************************
    // read selection
    // ****************************************
    wire         sel_st1  = (ptr_r == REG_STATUS1) | (ptr_r == REG_STATUS1_MIRROR);
    wire         sel_st2  = (ptr_r == REG_STATUS2) | (ptr_r == REG_STATUS2_MIRROR);
    wire  [7:0]  rd_sel   = sel_st1                     ? stat1_r :
                            sel_st2                     ? stat2_r :
                            (ptr_r == REG_CONFIG1)      ? config1_r :
                            (ptr_r == REG_CONFIG2)      ? config2_r :
                            (ptr_r == REG_CHMODE)       ? chmode_r :
                            (ptr_r == REG_ANALOG_OUT)   ? analog_output_pin_r :
                            (ptr_r == REG_VID_FANDIV)   ? {fandiv_r, code_s[3:0]} :
                            READ_UNMAPPED;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_byte_r <= READ_UNMAPPED;
        end else begin
            rd_byte_r <= rd_sel;
        end
    end

    // ****************************************
    // reset pin pulse
    // ****************************************
    logic [PULSE_W-1:0] pulse_cnt_r;
    logic               pulse_on_r;
    wire                pulse_go = wr_cfg1 & wr_data[CFG1_PULSE_BIT] & ~pulse_on_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pulse_on_r  <= 1'b0;
            pulse_cnt_r <= '0;
        end else if (pulse_go) begin
            pulse_on_r  <= 1'b1;
            pulse_cnt_r <= PULSE_W'(RST_PULSE_CYC - 1);
        end else if (pulse_on_r) begin
            if (pulse_cnt_r == '0) begin
                pulse_on_r <= 1'b0;
            end else begin
                pulse_cnt_r <= PULSE_W'(pulse_cnt_r - 1'b1);
            end
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    chan_roles_t roles_r;
    logic        zero_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            roles_r <= '0;
            zero_r  <= 1'b0;
        end else begin
            roles_r.tach_one_analog       <= chmode_r[CH_TACH_ONE];
            roles_r.tach_two_analog       <= chmode_r[CH_TACH_TWO];
            roles_r.diode_two_sel         <= chmode_r[CH_DIODE_TWO];
            roles_r.vcc_range_5v          <= chmode_r[CH_VCC_RANGE];
            roles_r.voltage_code_irq_mode <= chmode_r[CH_IRQ_MODE];
            roles_r.irq_enable            <= irq_en;
            zero_r                        <= 1'b0;
        end
    end

    assign sda_o              = zero_r;
    assign sda_oe             = sda_oe_r;
    assign rst_pin_o          = zero_r;
    assign rst_pin_oe         = pulse_on_r;
    assign chan_roles         = roles_r;
    assign analog_output_code = analog_output_pin_r;

endmodule
`default_nettype wire

// ===== design/hwmon_pkg.sv
// constants, types and register map of the monitor serial register port
`default_nettype none
package hwmon_pkg;
    // ****************************************
    // slave address
    // ****************************************
    localparam logic [4:0] SLAVE_ADDR_PREFIX  = 5'h0b;
    localparam logic [1:0] ADDR_LO_GND        = 2'h2;
    localparam logic [1:0] ADDR_LO_OPEN       = 2'h0;
    localparam logic [1:0] ADDR_LO_VCC        = 2'h1;
    localparam logic [1:0] STRAP_WAIT         = 2'h3;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] REG_CHMODE         = 8'h16;
    localparam logic [7:0] REG_ANALOG_OUT     = 8'h19;
    localparam logic [7:0] REG_CONFIG1        = 8'h40;
    localparam logic [7:0] REG_STATUS1        = 8'h41;
    localparam logic [7:0] REG_STATUS2        = 8'h42;
    localparam logic [7:0] REG_INTRUSION_CLR  = 8'h46;
    localparam logic [7:0] REG_VID_FANDIV     = 8'h47;
    localparam logic [7:0] REG_CONFIG2        = 8'h4a;
    localparam logic [7:0] REG_STATUS1_MIRROR = 8'h4c;
    localparam logic [7:0] REG_STATUS2_MIRROR = 8'h4d;
    localparam logic [7:0] READ_UNMAPPED      = 8'h00;

    // ****************************************
    // reset values and fields
    // ****************************************
    localparam logic [7:0] CHMODE_RST         = 8'h00;
    localparam logic [7:0] CONFIG1_RST        = 8'h08;
    localparam logic [7:0] CONFIG2_RST        = 8'h00;
    localparam logic [7:0] ANALOG_OUT_RST     = 8'hff;
    localparam logic [7:0] STATUS_RST         = 8'h00;
    localparam logic [3:0] FANDIV_RST         = 4'h5;
    localparam int         CFG1_PULSE_BIT     = 4;
    localparam int         CH_TACH_ONE        = 0;
    localparam int         CH_TACH_TWO        = 1;
    localparam int         CH_DIODE_TWO       = 2;
    localparam int         CH_VCC_RANGE       = 3;
    localparam int         CH_IRQ_MODE        = 7;
    localparam int         ST2_CHASSIS        = 5;

    // ****************************************
    // link bit counting and timing
    // ****************************************
    localparam logic [3:0] BIT_LAST           = 4'h7;
    localparam logic [3:0] BIT_ACK            = 4'h8;
    localparam int unsigned RST_PULSE_MS      = 45;
    localparam int unsigned CLK_FREQ_KHZ      = 100000;
    localparam int unsigned RST_PULSE_CYC_DFLT = RST_PULSE_MS * CLK_FREQ_KHZ;
    localparam int         PULSE_W            = $clog2(RST_PULSE_CYC_DFLT + 1);

    typedef enum logic [2:0] {
        LK_ADDR,
        LK_WR_PTR,
        LK_WR_DATA,
        LK_WR_IGNORE,
        LK_RD,
        LK_IDLE
    } link_state_t;

    typedef struct packed {
        logic tied_low;
        logic tied_high;
    } addr_sel_t;

    typedef struct packed {
        logic       is_data;
        logic [7:0] ptr;
        logic [7:0] data;
    } wr_event_t;

    typedef struct packed {
        logic       tach_one_analog;
        logic       tach_two_analog;
        logic       diode_two_sel;
        logic       vcc_range_5v;
        logic       voltage_code_irq_mode;
        logic [4:0] irq_enable;
    } chan_roles_t;
endpackage
`default_nettype wire

// ===== dv/monitor_smbus_register_port_monitor.sv
// assertion checker for the monitor serial register port
`default_nettype none
module monitor_smbus_register_port_monitor
    import hwmon_pkg::*;
#(
    parameter int unsigned RST_PULSE_CYC = 50
) (
    input wire logic        clk,                // system clock
    input wire logic        rst_n,              // reset
    input wire logic        scl_in,             // bus clock
    input wire logic        sda_i,              // data line
    input wire logic        sda_oe,             // data pull low
    input wire logic        rst_pin_i,          // reset pin level
    input wire logic        rst_pin_oe,         // reset pin pull low
    input wire addr_sel_t   addr_sel,           // strap sense
    input wire chan_roles_t chan_roles,         // pin roles
    input wire logic [7:0]  analog_output_code  // dac code
);
    logic        scl_q, sda_q, match_r, miss_r, rw_r;
    logic [5:0]  bitn_r;
    logic [7:0]  sh_r;
    logic [1:0]  strap_r;
    int unsigned pcnt_r;
    wire         rise_w  = scl_in && !scl_q;
    wire         start_w = scl_in && scl_q && sda_q && !sda_i;
    wire         stop_w  = scl_in && scl_q && !sda_q && sda_i;
    wire         hit_w   = sh_r[7:1] == {5'h0b, strap_r};

    // bus decoder sampled on the system clock
    always_ff @(posedge clk) begin
        scl_q  <= scl_in;
        sda_q  <= sda_i;
        pcnt_r <= (rst_n && rst_pin_oe) ? pcnt_r + 1 : 0;
        if (!rst_n) begin
            strap_r <= addr_sel.tied_low ? 2'h2 : {1'b0, addr_sel.tied_high};
        end
        if (!rst_n || start_w || stop_w) begin
            bitn_r  <= '0;
            match_r <= 1'b0;
            miss_r  <= 1'b0;
        end else if (rise_w) begin
            sh_r   <= {sh_r[6:0], sda_i};
            bitn_r <= bitn_r + 6'(bitn_r != 6'h3f);
            if (bitn_r == 6'h8) begin
                match_r <= hit_w;
                miss_r  <= !hit_w;
                rw_r    <= sh_r[0];
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_pin_held;
        !rst_pin_i [*6];
    endsequence

    a_addr_ack: assert property (rise_w && bitn_r == 6'h8 |-> sda_oe == hit_w)
        else $error("address acknowledge wrong");
    a_miss_idle: assert property (miss_r |-> !sda_oe)
        else $error("data line pulled after address miss");
    a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data line changed while clock high");
    a_wr_ack: assert property (match_r && !rw_r && rise_w && bitn_r inside {6'h11, 6'h1a} |-> sda_oe)
        else $error("write byte not acknowledged");
    a_extra_nack: assert property (match_r && !rw_r && rise_w && bitn_r == 6'h23 |-> !sda_oe)
        else $error("third write byte acknowledged");
    a_rd_single: assert property (match_r && rw_r && rise_w && bitn_r >= 6'h11 |-> !sda_oe)
        else $error("data line pulled after read byte");
    a_pulse_len: assert property ($fell(rst_pin_oe) |-> pcnt_r == RST_PULSE_CYC)
        else $error("reset pulse length wrong");
    a_pin_clear: assert property (s_pin_held |-> chan_roles == '0 && analog_output_code == 8'hff)
        else $error("reset pin did not restore defaults");
endmodule

bind monitor_smbus_register_port monitor_smbus_register_port_monitor #(.RST_PULSE_CYC(RST_PULSE_CYC)) mon_u (
    .clk(clk), .rst_n(rst_n), .scl_in(scl_in), .sda_i(sda_i), .sda_oe(sda_oe), .rst_pin_i(rst_pin_i),
    .rst_pin_oe(rst_pin_oe), .addr_sel(addr_sel), .chan_roles(chan_roles),
    .analog_output_code(analog_output_code)
);
`default_nettype wire

// ===== dv/smbus_master_model.sv
// serial bus master model facing the monitor register port
`default_nettype none
module smbus_master_model (
    output logic     scl,    // bus clock, high between frames
    output logic     sda_m,  // data drive, 1 releases the line
    input wire logic sda     // resolved data line
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end

    // one bit: data set in the low phase, sampled at the rise
    task automatic bit_io(input logic b, output logic s);
        #8 sda_m = b;
        #8 scl = 1'b1;
        s = sda;
        #16 scl = 1'b0;
    endtask

    task automatic byte_io(input logic [7:0] b, output logic [7:0] r, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], s);
            r[i] = s;
        end
        bit_io(1'b1, s);
        ack = !s;
    endtask

    // start, address, n write bytes from the top of d or n read bytes, stop
    task automatic xfer(input logic [6:0] a, input logic rw, input int n, input logic [23:0] d,
                        output logic [7:0] r, output logic [3:0] acks);
        logic ack;
        acks = '0;
        sda_m = 1'b0;
        #16 scl = 1'b0;
        byte_io({a, rw}, r, ack);
        acks[0] = ack;
        for (int i = 1; i <= n; i++) begin
            byte_io(rw ? 8'hff : d[24 - 8 * i +: 8], r, ack);
            acks[i] = ack;
        end
        #8 sda_m = 1'b0;
        #8 scl = 1'b1;
        #16 sda_m = 1'b1;
        #16;
    endtask
endmodule
`default_nettype wire

// ===== dv/monitor_smbus_register_port_bench.sv
// self-checking bench of the monitor serial register port
`default_nettype none
module monitor_smbus_register_port_bench import hwmon_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned PULSE = 50;
    logic        clk = 1'b0, rst_n = 1'b0, chassis_in = 1'b0;
    logic        scl, sda_m, sda_oe, sda_o, pin_oe, pin_o;
    logic [7:0]  limit_events = 8'h00;
    logic [7:0]  dac, q, v, cfg2, r;
    addr_sel_t   addr_sel = '0;
    logic [4:0]  code = 5'h1f;
    chan_roles_t chan_roles;
    logic [31:0] seed = 32'h0000004a;
    logic [3:0]  acks;
    logic [6:0]  dev;
    int          n_errors = 0, n_tests = 0, n_pulse = 0;
    logic [6:0]  adr [3] = '{7'h2c, 7'h2e, 7'h2d};
    logic [1:0]  sel [3] = '{2'h0, 2'h2, 2'h1};
    logic [7:0]  st [4] = '{8'h41, 8'h4c, 8'h42, 8'h4d};
    wire         sda = sda_m & (sda_oe ? sda_o : 1'b1);
    wire         pin = pin_oe ? pin_o : 1'b1;

    always #5 clk = ~clk;
    always @(posedge clk) if (pin_oe === 1'b1) n_pulse <= n_pulse + 1;

    smbus_master_model m_u (.scl(scl), .sda_m(sda_m), .sda(sda));
    monitor_smbus_register_port #(.RST_PULSE_CYC(PULSE)) dut_u (
        .clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
        .rst_pin_i(pin), .rst_pin_o(pin_o), .rst_pin_oe(pin_oe), .addr_sel(addr_sel),
        .chassis_in(chassis_in), .core_voltage_code(code), .limit_events(limit_events),
        .chan_roles(chan_roles), .analog_output_code(dac)
    );

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // expected roles: tach/analog, diode, range, irq mode, five enables
    function automatic logic [9:0] roles(input logic [7:0] m, input logic [7:0] c2);
        return {m[0], m[1], m[2], m[3], m[7], c2[7:6], m[6:4]};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        n_tests++;
        if (seen !== want) begin
            n_errors++;
            $display("ERROR at %0t ns: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic wreg(input logic [7:0] a, input logic [7:0] d, input int n);
        m_u.xfer(dev, 1'b0, n, {a, d, d ^ 8'h5a}, r, acks);
    endtask

    task automatic rd(output logic [7:0] d);
        m_u.xfer(dev, 1'b1, 1, 24'h0, d, acks);
    endtask

    task automatic rreg(input logic [7:0] a, output logic [7:0] d);
        wreg(a, 8'h00, 1);
        rd(d);
    endtask

    task automatic power_up(input logic [1:0] s);
        @(posedge clk);
        rst_n <= 1'b0;
        addr_sel <= addr_sel_t'(s);
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (12) @(posedge clk);
    endtask

    task automatic print_verdict();
        $display("errors %0d, comparisons %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        #600us;
        n_errors++;
        print_verdict();
    end

    initial begin
        for (int s = 0; s < 3; s++) begin
            power_up(sel[s]);
            dev = adr[(s + 1) % 3];
            wreg(REG_CHMODE, 8'h00, 1);
            chk(acks[0], 1'b0);
            @(posedge clk);
            addr_sel <= addr_sel_t'(sel[(s + 1) % 3]);
            dev = adr[s];
            rreg(REG_CHMODE, q);
            chk(acks[0], 1'b1);
            chk(q, 8'h00);
            chk({chan_roles, dac}, {10'h000, 8'hff});
        end
        for (int i = 0; i < 6; i++) begin
            v = 8'(rnd());
            cfg2 = 8'(rnd()) & 8'hc0;
            wreg(REG_CONFIG2, cfg2, 2);
            wreg(REG_CHMODE, v, 2);
            chk(acks, 4'h7);
            rreg(REG_CHMODE, q);
            chk(q, v);
            rd(q);
            chk(q, v);
            chk(chan_roles & (v[7] ? 10'h3ff : 10'h3e0), roles(v, cfg2) & (v[7] ? 10'h3ff : 10'h3e0));
        end
        wreg(REG_ANALOG_OUT, 8'h3c, 3);
        chk(acks, 4'h7);
        wreg(REG_ANALOG_OUT, 8'h00, 1);
        chk(dac, 8'h3c);
        wreg(REG_CHMODE, 8'hf0, 2);
        wreg(REG_CONFIG2, 8'hc0, 2);
        v = 8'(rnd()) | 8'h01;
        @(posedge clk);
        limit_events <= v;
        chassis_in <= 1'b1;
        code <= 5'h00;
        repeat (4) @(posedge clk);
        limit_events <= 8'h00;
        chassis_in <= 1'b0;
        code <= 5'h1f;
        foreach (st[k]) begin
            rreg(st[k], q);
            chk(q, k < 2 ? v : 8'h3f);
        end
        wreg(REG_STATUS1, v, 2);
        wreg(REG_INTRUSION_CLR, 8'h00, 2);
        rreg(REG_STATUS1_MIRROR, q);
        chk(q, 8'h00);
        rreg(8'h4d, q);
        chk(q, 8'h1f);
        wreg(REG_VID_FANDIV, 8'ha0, 2);
        wreg(REG_CHMODE, 8'hff, 2);
        wreg(REG_CONFIG1, 8'h18, 2);
        repeat (PULSE + 20) @(posedge clk);
        chk(n_pulse, PULSE);
        rreg(REG_CHMODE, q);
        chk(q, 8'h00);
        rreg(REG_CONFIG1, q);
        chk(q, 8'h08);
        rreg(REG_VID_FANDIV, q);
        chk(q, 8'h5f);
        rreg(8'h7f, q);
        chk(q, 8'h00);
        print_verdict();
    end
endmodule
`default_nettype wire
